/* timer_channel_irq_enable.sv */
// six-channel timer interrupt enable, status flags and ahb-lite register slave
// Operation
// RL1: each of the six channels owns its own enable register, gating only that channel's requests.
// RL2: with the conversion-trigger enable (bit 7) set, a register A match or capture issues a conversion start.
// RL3: enable bit 6 always reads 1 and ignores writes.
// RL4: in channels 1, 2, 4 and 5 the underflow request is flag AND enable bit 5.
// RL5: in channels 0 and 3 enable bit 5 reads 0, ignores writes and never gives an underflow request.
// RL6: in every channel the overflow request is flag AND enable bit 4.
// RL7: in channels 0 and 3 the D request is the D flag AND enable bit 3.
// RL8: in channels 1, 2, 4 and 5 enable bit 3 reads 0 and ignores writes.
// RL9: in channels 0 and 3 the C request is the C flag AND enable bit 2.
// RL10: in channels 1, 2, 4 and 5 enable bit 2 reads 0 and ignores writes.
// RL11: in every channel the B request is the B flag AND enable bit 1.
// RL12: in every channel the A request is the A flag AND enable bit 0.
// RL13: the underflow flag sets when the counter in phase counting mode goes from 0x0000 to 0xffff.
// RL14: the overflow flag sets when the counter goes from 0xffff to 0x0000.
// RL15: a flag clears only when written 0 after having been read as 1, removing its request.
// RL16: each request is a level equal to flag AND enable, following either within one clock.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module timer_channel_irq_enable #(
    parameter int N_CH = timer_irq_pkg::N_CH
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [timer_irq_pkg::ADDR_W-1:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // counter side, same clock domain
    input wire logic [N_CH*timer_irq_pkg::CNT_W-1:0] channel_counter_in,
    input wire logic [N_CH-1:0] phase_count_mode_in,
    input wire logic [N_CH-1:0] count_up_in,
    input wire logic [N_CH*4-1:0] match_event_in,
    // requests
    output logic [N_CH-1:0] underflow_irq_out,
    output logic [N_CH-1:0] overflow_irq_out,
    output logic [N_CH-1:0] match_d_irq_out,
    output logic [N_CH-1:0] match_c_irq_out,
    output logic [N_CH-1:0] match_b_irq_out,
    output logic [N_CH-1:0] match_a_irq_out,
    output logic [N_CH-1:0] conv_start_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state so read data leaves a flip-flop

    logic active_r;
    logic write_r;
    logic [timer_irq_pkg::ADDR_W-1:0] addr_r;
    logic accept;
    logic do_wr;
    logic do_rd;
    logic [2:0] reg_idx;
    logic [2:0] reg_grp;
    logic idx_ok;
    logic sel_enable;
    logic sel_status;
    logic sel_pend;
    logic sel_mask;
    logic [31:0] rd_val;

    assign accept = hsel_in & htrans_in[1] & hready_in;
    assign do_wr = active_r & write_r;
    assign do_rd = active_r & ~write_r;
    assign reg_idx = addr_r[4:2];
    assign reg_grp = addr_r[7:5];
    assign idx_ok = (32'(reg_idx) < N_CH);
    assign sel_enable = (reg_grp == timer_irq_pkg::ENABLE_BASE[7:5]) && idx_ok;
    assign sel_status = (reg_grp == timer_irq_pkg::STATUS_BASE[7:5]) && idx_ok;
    assign sel_pend = (addr_r == timer_irq_pkg::IRQ_PEND_OFS);
    assign sel_mask = (addr_r == timer_irq_pkg::IRQ_MASK_OFS);

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            active_r <= 1'b0;
            write_r <= 1'b0;
            addr_r <= '0;
            hreadyout_out <= 1'b1;
        end else begin
            active_r <= accept;
            hreadyout_out <= ~accept;
            if (accept) begin
                write_r <= hwrite_in;
                addr_r <= {haddr_in[timer_irq_pkg::ADDR_W-1:2], 2'b00};
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hrdata_out <= 32'h0000_0000;
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
            if (do_rd) begin
                hrdata_out <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel registers

    logic [N_CH-1:0][7:0] enable_view;
    logic [N_CH-1:0][7:0] status_view;
    logic [N_CH-1:0] req_any;
    // rise of the OR of this channel's gated requests, one cycle, feeds the pending register
    logic [N_CH-1:0] req_rise;

    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++) begin : g_ch
            localparam bit HAS_UF = timer_irq_pkg::UNDERFLOW_CHANNELS[ch];
            localparam bit HAS_CD = timer_irq_pkg::MATCH_CD_CHANNELS[ch];
            // only bits that exist in this channel are storable
            localparam logic [7:0] WMASK = timer_irq_pkg::ENABLE_COMMON_MASK
                | (HAS_UF ? timer_irq_pkg::ENABLE_UNDERFLOW_MASK : 8'h00)
                | (HAS_CD ? timer_irq_pkg::ENABLE_MATCH_CD_MASK : 8'h00);
            localparam logic [7:0] FMASK = {2'b00, HAS_UF, 1'b1, HAS_CD, HAS_CD, 2'b11};

            logic [7:0] enable_r;
            logic [7:0] flag_r;
            logic [7:0] armed_r;
            logic [7:0] flag_set;
            logic [7:0] flag_clr;
            logic [15:0] cnt_prev_r;
            logic [15:0] cnt_cur;
            logic [3:0] mev;
            logic wr_en;
            logic wr_st;
            logic rd_st;
            logic [7:0] gated;
            logic req_prev_r;

            assign cnt_cur = channel_counter_in[ch*timer_irq_pkg::CNT_W +: timer_irq_pkg::CNT_W];
            assign mev = match_event_in[ch*4 +: 4];
            assign wr_en = do_wr && sel_enable && (32'(reg_idx) == ch);
            assign wr_st = do_wr && sel_status && (32'(reg_idx) == ch);
            assign rd_st = do_rd && sel_status && (32'(reg_idx) == ch);

            // enable register, reserved bits held at zero
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    enable_r <= timer_irq_pkg::ENABLE_RESET & WMASK;
                end else if (wr_en) begin
                    enable_r <= hwdata_in[7:0] & WMASK; // RL1 RL5 RL8 RL10
                end
            end
            assign enable_view[ch] = enable_r | timer_irq_pkg::ENABLE_FIXED_ONES; // RL3

            // counter wrap detection
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    cnt_prev_r <= timer_irq_pkg::CNT_MIN;
                end else begin
                    cnt_prev_r <= cnt_cur;
                end
            end

            always_comb begin
                flag_set = 8'h00;
                flag_set[timer_irq_pkg::UNDERFLOW_FLAG_BIT] = HAS_UF && phase_count_mode_in[ch]
                    && (cnt_prev_r == timer_irq_pkg::CNT_MIN) && (cnt_cur == timer_irq_pkg::CNT_MAX); // RL13
                flag_set[timer_irq_pkg::OVERFLOW_FLAG_BIT] = (cnt_prev_r == timer_irq_pkg::CNT_MAX)
                    && (cnt_cur == timer_irq_pkg::CNT_MIN); // RL14
                flag_set[timer_irq_pkg::MATCH_D_FLAG_BIT] = HAS_CD && mev[3];
                flag_set[timer_irq_pkg::MATCH_C_FLAG_BIT] = HAS_CD && mev[2];
                flag_set[timer_irq_pkg::MATCH_B_FLAG_BIT] = mev[1];
                flag_set[timer_irq_pkg::MATCH_A_FLAG_BIT] = mev[0];
            end

            // clear needs a prior read of 1; a new event in the same cycle wins
            assign flag_clr = wr_st ? (armed_r & ~hwdata_in[7:0] & FMASK) : 8'h00; // RL15

            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    flag_r <= timer_irq_pkg::FLAG_RESET;
                end else begin
                    flag_r <= ((flag_r & ~flag_clr) | flag_set) & FMASK; // RL15
                end
            end

            // a write consumes the arming, whatever bits it cleared
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    armed_r <= 8'h00;
                end else if (wr_st) begin
                    armed_r <= 8'h00;
                end else if (rd_st) begin
                    armed_r <= armed_r | flag_r; // RL15
                end
            end

            assign status_view[ch] = flag_r | timer_irq_pkg::STATUS_FIXED_ONES
                | {(HAS_UF ? count_up_in[ch] : 1'b1), 7'h00};

            assign gated = flag_r & enable_r; // RL16

            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    underflow_irq_out[ch] <= 1'b0;
                    overflow_irq_out[ch] <= 1'b0;
                    match_d_irq_out[ch] <= 1'b0;
                    match_c_irq_out[ch] <= 1'b0;
                    match_b_irq_out[ch] <= 1'b0;
                    match_a_irq_out[ch] <= 1'b0;
                end else begin
                    underflow_irq_out[ch] <= gated[timer_irq_pkg::UNDERFLOW_IRQ_EN_BIT]; // RL4 RL5
                    overflow_irq_out[ch] <= gated[timer_irq_pkg::OVERFLOW_IRQ_EN_BIT]; // RL6
                    match_d_irq_out[ch] <= gated[timer_irq_pkg::MATCH_D_IRQ_EN_BIT]; // RL7
                    match_c_irq_out[ch] <= gated[timer_irq_pkg::MATCH_C_IRQ_EN_BIT]; // RL9
                    match_b_irq_out[ch] <= gated[timer_irq_pkg::MATCH_B_IRQ_EN_BIT]; // RL11
                    match_a_irq_out[ch] <= gated[timer_irq_pkg::MATCH_A_IRQ_EN_BIT]; // RL12
                end
            end

            // conversion start is a one-cycle pulse per register A event
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    conv_start_out[ch] <= 1'b0;
                end else begin
                    conv_start_out[ch] <= mev[0] & enable_r[timer_irq_pkg::CONV_TRIGGER_EN_BIT]; // RL2
                end
            end

            assign req_any[ch] = |gated[5:0];

            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    req_prev_r <= 1'b0;
                end else begin
                    req_prev_r <= req_any[ch];
                end
            end
            assign req_rise[ch] = req_any[ch] & ~req_prev_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // summary interrupt: sticky per channel, write one to clear

    // a standing request sets pending once; it must drop before a new rise counts
    logic [N_CH-1:0] pend_r;
    logic [N_CH-1:0] mask_r;
    logic [N_CH-1:0] pend_clr;

    assign pend_clr = (do_wr && sel_pend) ? hwdata_in[N_CH-1:0] : '0;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_r <= timer_irq_pkg::PEND_RESET[N_CH-1:0];
        end else begin
            // a rising request in the clearing cycle stays pending
            pend_r <= (pend_r & ~pend_clr) | req_rise;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_r <= timer_irq_pkg::MASK_RESET[N_CH-1:0];
        end else if (do_wr && sel_mask) begin
            mask_r <= hwdata_in[N_CH-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(pend_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero

    always_comb begin
        rd_val = 32'h0000_0000;
        if (sel_enable) begin
            rd_val[7:0] = enable_view[reg_idx];
        end else if (sel_status) begin
            rd_val[7:0] = status_view[reg_idx];
        end else if (sel_pend) begin
            rd_val[N_CH-1:0] = pend_r;
        end else if (sel_mask) begin
            rd_val[N_CH-1:0] = mask_r;
        end
    end

endmodule

`default_nettype wire

/* timer_irq_pkg.sv */
// constants for the timer channel interrupt enable block
package timer_irq_pkg;
    localparam int N_CH = 6;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] ENABLE_BASE = 8'h00;
    localparam logic [7:0] STATUS_BASE = 8'h20;
    localparam logic [7:0] IRQ_PEND_OFS = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h44;
    // enable register fields
    localparam int CONV_TRIGGER_EN_BIT = 7;
    localparam int FIXED_ONE_BIT = 6;
    localparam int UNDERFLOW_IRQ_EN_BIT = 5;
    localparam int OVERFLOW_IRQ_EN_BIT = 4;
    localparam int MATCH_D_IRQ_EN_BIT = 3;
    localparam int MATCH_C_IRQ_EN_BIT = 2;
    localparam int MATCH_B_IRQ_EN_BIT = 1;
    localparam int MATCH_A_IRQ_EN_BIT = 0;
    // status register fields
    localparam int DIR_BIT = 7;
    localparam int UNDERFLOW_FLAG_BIT = 5;
    localparam int OVERFLOW_FLAG_BIT = 4;
    localparam int MATCH_D_FLAG_BIT = 3;
    localparam int MATCH_C_FLAG_BIT = 2;
    localparam int MATCH_B_FLAG_BIT = 1;
    localparam int MATCH_A_FLAG_BIT = 0;
    // reset and read-back values
    localparam logic [7:0] ENABLE_RESET = 8'h40;
    localparam logic [7:0] ENABLE_FIXED_ONES = 8'h40;
    localparam logic [7:0] STATUS_FIXED_ONES = 8'h40;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [5:0] PEND_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;
    // enable bits writable in every channel, then in the underflow and c/d channel classes only
    localparam logic [7:0] ENABLE_COMMON_MASK = 8'h93;
    localparam logic [7:0] ENABLE_UNDERFLOW_MASK = 8'h20;
    localparam logic [7:0] ENABLE_MATCH_CD_MASK = 8'h0c;
    // channel classes: bit n is channel n
    localparam logic [5:0] UNDERFLOW_CHANNELS = 6'h36;
    localparam logic [5:0] MATCH_CD_CHANNELS = 6'h09;
    // counter wrap points
    localparam logic [15:0] CNT_MIN = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage

/* timer_irq_monitor.sv */
// assertion checker for the timer interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module timer_irq_monitor #(
    parameter int N_CH = timer_irq_pkg::N_CH
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [N_CH*4-1:0] match_event_in,
    input wire logic [N_CH-1:0] underflow_irq_out,
    input wire logic [N_CH-1:0] match_d_irq_out,
    input wire logic [N_CH-1:0] match_c_irq_out,
    input wire logic [N_CH-1:0] match_a_irq_out,
    input wire logic [N_CH-1:0] conv_start_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    logic take;
    logic wr_dp_r;
    logic [N_CH-1:0] a_ev;
    assign take = hsel_in & htrans_in[1] & hready_in;
    always_comb begin
        for (int n = 0; n < N_CH; n++) begin
            a_ev[n] = match_event_in[4*n];
        end
    end
    // write lands at the edge closing this phase
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_dp_r <= 1'b0;
        end else begin
            wr_dp_r <= take & hwrite_in;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_resp_okay: assert property (hresp_out == 1'b0)
        else $error("response not okay");
    chk_one_wait: assert property (take |=> !hreadyout_out ##1 hreadyout_out)
        else $error("wait state missing");
    chk_wait_end: assert property (!hreadyout_out |=> hreadyout_out)
        else $error("wait state too long");
    chk_conv_cause: assert property ((conv_start_out & ~$past(a_ev)) == '0)
        else $error("conversion start without event");
    chk_uf_reserved: assert property ((underflow_irq_out & 6'h09) == '0)
        else $error("underflow request on channel 0 or 3");
    chk_cd_reserved: assert property (((match_c_irq_out | match_d_irq_out) & 6'h36) == '0)
        else $error("c or d request on wrong channel");
    chk_a_cause: assert property ($rose(match_a_irq_out[0]) |-> $past(a_ev[0], 2) || $past(wr_dp_r, 2))
        else $error("a request rose without cause");
    chk_a_drop: assert property ($fell(match_a_irq_out[0]) |-> $past(wr_dp_r, 2))
        else $error("a request fell without write");
endmodule
bind timer_channel_irq_enable timer_irq_monitor #(.N_CH(N_CH)) u_mon (.mclk_in, .arst_n_in, .hsel_in,
    .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hresp_out, .match_event_in, .underflow_irq_out,
    .match_d_irq_out, .match_c_irq_out, .match_a_irq_out, .conv_start_out);
`default_nettype wire

/* timer_irq_partner.sv */
// converter stand-in counting conversion start requests
`timescale 1ns/1ps
`default_nettype none
module timer_irq_partner (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic [5:0] conv_start_in,
    output int conv_count_out
);
    ////////////////////////////////////////////////////////////////
    // one conversion per pulse, overlapping channels counted once
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_count_out <= 0;
        end else if (conv_start_in != 6'h00) begin
            conv_count_out <= conv_count_out + 1;
        end
    end
endmodule
`default_nettype wire

/* tb_timer_channel_irq_enable.sv */
// self-checking bench for the timer interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_irq_enable;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [95:0] cnt = '0;
    logic [5:0] mode = 6'h00;
    logic [23:0] ev = 24'h0;
    logic [5:0] uf, ov, md, mc, mb, ma, conv;
    logic irq;
    int conv_n;
    int failures = 0;
    int compares = 0;
    timer_channel_irq_enable u_dut (.mclk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .channel_counter_in(cnt), .phase_count_mode_in(mode),
        .count_up_in(6'h00), .match_event_in(ev), .underflow_irq_out(uf), .overflow_irq_out(ov),
        .match_d_irq_out(md), .match_c_irq_out(mc), .match_b_irq_out(mb), .match_a_irq_out(ma),
        .conv_start_out(conv), .irq_out(irq));
    timer_irq_partner u_far (.mclk_in(clk), .arst_n_in(rst_n), .conv_start_in(conv), .conv_count_out(conv_n));
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, {24'h0, d}, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, x, exp);
    endtask
    task automatic pulse(input logic [23:0] v);
        ev <= v;
        @(posedge clk);
        ev <= '0;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int n = 0; n < 6; n++) begin
            rdc("enable reset", 8'(4*n), 32'h40);
            wr(8'(4*n), 8'hff);
            rdc("enable all", 8'(4*n), (n % 3 == 0) ? 32'hdf : 32'hf3);
            wr(8'(4*n), 8'h00);
            rdc("enable none", 8'(4*n), 32'h40);
        end
        rdc("unmapped", 8'h80, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_match;
        logic [31:0] x;
        for (int n = 0; n < 6; n++) wr(8'(4*n), 8'h0f);
        pulse(24'hffffff);
        chk("a req", ma, 6'h3f);
        chk("b req", mb, 6'h3f);
        chk("c req", mc, 6'h09);
        chk("d req", md, 6'h09);
        wr(8'h04, 8'h00);
        repeat (2) @(posedge clk);
        chk("a gated", ma, 6'h3d);
        wr(8'h20, 8'h00);
        repeat (2) @(posedge clk);
        chk("unread clear", ma, 6'h3d);
        bus(1'b0, 8'h20, 32'h0, x);
        chk("status", x, 32'hcf);
        wr(8'h20, 8'h00);
        repeat (2) @(posedge clk);
        chk("cleared", ma, 6'h3c);
        $display("test match done");
    endtask
    task automatic t_conv;
        int c0;
        c0 = conv_n;
        wr(8'h08, 8'h80);
        ev <= 24'h000101;
        @(posedge clk);
        ev <= '0;
        @(posedge clk);
        chk("conv pulse", conv, 6'h04);
        repeat (2) @(posedge clk);
        chk("conv end", conv, 6'h00);
        chk("conv count", 32'(conv_n - c0), 32'h1);
        $display("test conv done");
    endtask
    task automatic t_wrap;
        for (int n = 0; n < 6; n++) wr(8'(4*n), 8'h30);
        cnt <= {6{16'hffff}};
        repeat (4) @(posedge clk);
        chk("uf off mode", uf, 6'h00);
        cnt <= '0;
        repeat (4) @(posedge clk);
        chk("overflow", ov, 6'h3f);
        mode <= 6'h3f;
        cnt <= {6{16'hffff}};
        repeat (4) @(posedge clk);
        chk("underflow", uf, 6'h36);
        $display("test wrap done");
    endtask
    task automatic t_irq;
        wr(8'h00, 8'h00);
        wr(8'h44, 8'h00);
        wr(8'h40, 8'h3f);
        wr(8'h00, 8'h01);
        pulse(24'h000001);
        rdc("pending", 8'h40, 32'h01);
        chk("masked", irq, 1'b0);
        wr(8'h44, 8'h01);
        repeat (2) @(posedge clk);
        chk("unmasked", irq, 1'b1);
        wr(8'h40, 8'h01);
        repeat (2) @(posedge clk);
        chk("acked", irq, 1'b0);
        $display("test irq done");
    endtask
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_match;
        t_conv;
        t_wrap;
        t_irq;
        end_sim;
    end
endmodule
`default_nettype wire
